// >>> prs_rail_seq.v
// Pulse count command decoder and rail sequencer with register access.
`timescale 1ns/10ps
`default_nettype none
`include "prs_defs.vh"

module prs_rail_seq #(
  parameter STOP_CYC = `PRS_STOP_CYC,
  parameter OFF_CYC = `PRS_OFF_CYC,
  parameter FDA_CYC = `PRS_FDA_CYC
) (
  input wire i_core_clk, // 40 MHz clock
  input wire i_rst, // Async reset, active high
  input wire i_pulse_wire_in, // Pulse wire, pulled low outside
  input wire i_analog_rail_enable, // Analog rail enable pin
  input wire i_undervolt_lockout, // Input supply below lockout
  input wire i_overtemp, // Die above 140 C
  input wire i_cooled, // Die cooled 10 C below trip
  input wire i_pos_pump_good, // Positive pump rail settled
  input wire i_neg_pump_good, // Negative pump rail settled
  input wire i_vin_above_target, // Input above pump target
  input wire [2:0] i_below_80, // Output below 80%: neg, pos, analog
  input wire [1:0] i_sw_on_req, // Switch on-period request: neg, pos pump
  input wire [1:0] i_sw_oc, // Switch overcurrent seen
  input wire [3:0] i_avs_address, // Avalon byte address
  input wire i_avs_read, // Avalon read
  input wire i_avs_write, // Avalon write
  input wire [31:0] i_avs_writedata, // Avalon write data
  output reg [31:0] o_avs_readdata, // Avalon read data
  output wire o_avs_waitrequest, // Avalon wait request
  output wire [1:0] o_sw_gate, // Switch gate drive
  output reg o_shutdown, // Low-current shutdown state
  output reg o_analog_rail_en, // Analog rail on
  output reg o_pos_pump_en, // Positive pump on
  output reg o_neg_pump_en, // Negative pump on
  output reg o_pos_pump_bypass, // Pump in unity bypass
  output reg [5:0] o_pos_pump_target, // Pump target, 0.1V units
  output reg o_panel_pos_rail_en, // Positive panel rail on
  output reg o_panel_neg_rail_en, // Negative panel rail on
  output reg [2:0] o_pos_code, // Positive rail code
  output reg [2:0] o_neg_code, // Negative rail code
  output reg o_analog_fast_discharge, // Analog rail discharge
  output reg o_pos_fast_discharge, // Positive panel rail discharge
  output reg o_neg_timed_fast_discharge, // Negative rail timed discharge
  output reg o_neg_slow_discharge, // Negative rails slow discharge
  output reg o_pos_hiz, // Positive panel rail floating
  output reg o_neg_hiz, // Negative panel rail floating
  output reg o_short_fault_latch // Latched short fault
);

  // Counter end points, cut to the timer width on purpose
  localparam integer STOP_LAST_I = STOP_CYC - 1;
  localparam integer OFF_LAST_I = OFF_CYC - 1;
  localparam integer FDA_END_I = FDA_CYC;
  localparam [`PRS_TMR_W-1:0] STOP_LAST = STOP_LAST_I[`PRS_TMR_W-1:0];
  localparam [`PRS_TMR_W-1:0] OFF_LAST = OFF_LAST_I[`PRS_TMR_W-1:0];
  localparam [`PRS_TMR_W-1:0] FDA_END = FDA_END_I[`PRS_TMR_W-1:0];

  // Pulse wire state and discharge timers
  reg wire_d_r;
  reg wire_off_r;
  reg [4:0] cnt_r;
  reg [`PRS_TMR_W-1:0] hi_cnt_r;
  reg [`PRS_TMR_W-1:0] lo_cnt_r;
  reg [`PRS_TMR_W-1:0] fda_cnt_r;
  reg [`PRS_TMR_W-1:0] slow_cnt_r;

  // Command state
  reg [4:0] last_cmd_r;
  reg pos_on_r;
  reg neg_on_r;
  reg neg_slow_r;

  // Protection and bus state
  reg otp_r;
  reg ack_r;
  reg [1:0] oc_lat_r;

  // Pins are taken as synchronous to the clock
  wire en = i_analog_rail_enable;
  wire pw = i_pulse_wire_in;
  wire rise = pw & ~wire_d_r;
  // A session ends when the wire has stood high for the stop time
  wire stop_hit = pw & ~wire_off_r & (hi_cnt_r == STOP_LAST) & (cnt_r != 5'h00);
  // Wire low past the off delay shuts the panel converters
  wire off_hit = ~pw & (lo_cnt_r == OFF_LAST);
  wire both_low = ~en & ~pw;
  // Register bus
  wire req = i_avs_read | i_avs_write;
  wire sw_cmd = i_avs_write & ack_r & (i_avs_address == `PRS_REG_CMD);
  // Wire commands win; a software command in the same cycle is dropped
  wire do_cmd = stop_hit | sw_cmd;
  wire [4:0] cmd = stop_hit ? cnt_r : i_avs_writedata[4:0];

  // Command decode, one flag per kind of count
  wire cmd_pos_set = (cmd >= `PRS_CMD_POS_LO) && (cmd <= `PRS_CMD_POS_HI);
  wire cmd_neg_set = (cmd >= `PRS_CMD_NEG_LO) && (cmd <= `PRS_CMD_NEG_HI);
  wire cmd_pos_on = (cmd == `PRS_CMD_POS_ON);
  wire cmd_neg_on = (cmd == `PRS_CMD_NEG_ON);
  wire cmd_pos_off = (cmd == `PRS_CMD_POS_OFF);
  wire cmd_neg_off = (cmd == `PRS_CMD_NEG_OFF);
  wire cmd_neg_slow = (cmd == `PRS_CMD_NEG_SLOW);
  wire cmd_defaults = (cmd == `PRS_CMD_SOFT_RST);
  // Reserved counts raise none of the flags and change nothing but last_cmd_r

  wire lock_hold = i_undervolt_lockout;
  wire hot_hold = otp_r;
  wire ok = ~lock_hold & ~hot_hold & ~o_short_fault_latch;
  // Negative rail discharges fast only for a limited window
  wire fda_act = ~en & (fda_cnt_r < FDA_END);
  wire slow_act = neg_slow_r & (slow_cnt_r < FDA_END);
  // Largest magnitude among the three rails, in 0.1V units
  wire [5:0] pos_mag = `PRS_POS_BASE + {3'h0, o_pos_code};
  wire [5:0] neg_mag = `PRS_NEG_BASE - {3'h0, o_neg_code};
  wire [5:0] max_pa = (pos_mag > `PRS_ANALOG_RAIL_MAG) ? pos_mag : `PRS_ANALOG_RAIL_MAG;
  wire [5:0] max_all = (neg_mag > max_pa) ? neg_mag : max_pa;
  // Positive pump runs once either input has woken the block
  wire pos_pump_nxt = (en | ~wire_off_r) & ok;
  // The negative pump inverts the positive rail, so it waits for it
  wire neg_pump_nxt = pos_pump_nxt & i_pos_pump_good;
  // Panel rails need the wire awake, their own on flag and a good pump
  wire pos_rail_nxt = ~wire_off_r & pos_on_r & pos_pump_nxt & i_pos_pump_good;
  wire neg_rail_nxt = ~wire_off_r & neg_on_r & ~neg_slow_r & neg_pump_nxt & i_neg_pump_good;
  wire [2:0] rails_on = {o_panel_neg_rail_en, o_panel_pos_rail_en, o_analog_rail_en};
  // Only a rail that is meant to be up can count as shorted
  wire short_set = |(i_below_80 & rails_on);
  // Lockout or a long joint low of both inputs clears the latch
  wire short_clr = i_undervolt_lockout | (off_hit & ~en);

  // Next values of the rail, discharge and float controls
  wire an_rail_nxt = en & ok;
  wire an_fd_nxt = ~en;
  wire pos_fd_nxt = ~en & ~pos_rail_nxt;
  wire neg_fda_nxt = fda_act & ~neg_rail_nxt & ~slow_act;
  wire neg_slow_nxt = slow_act & ~neg_rail_nxt;
  wire pos_hiz_nxt = en & ~pos_rail_nxt;
  wire neg_hiz_nxt = ~neg_rail_nxt & ~fda_act & ~slow_act;
  wire [5:0] target_nxt = max_all + `PRS_HEADROOM;

  // One wait cycle gives time to register the read data
  assign o_avs_waitrequest = req & ~ack_r;

  // Gate drops in the same cycle the overcurrent appears; the latch keeps it
  // off for the rest of that on-period even if the sense input recovers
  wire [1:0] pump_on = {o_neg_pump_en, o_pos_pump_en};
  wire [1:0] oc_block = oc_lat_r | i_sw_oc;
  assign o_sw_gate = i_sw_on_req & ~oc_block & pump_on;

  // Timers saturate, so a wire parked high or low never wraps
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wire_d_r <= 1'b0;
      wire_off_r <= 1'b1;
      cnt_r <= 5'h00;
      hi_cnt_r <= {`PRS_TMR_W{1'b0}};
      lo_cnt_r <= {`PRS_TMR_W{1'b0}};
    end else begin
      wire_d_r <= pw;
      if (pw) begin
        lo_cnt_r <= {`PRS_TMR_W{1'b0}};
        if (rise) begin
          hi_cnt_r <= {`PRS_TMR_W{1'b0}};
        end else if (hi_cnt_r != STOP_LAST) begin
          hi_cnt_r <= hi_cnt_r + 1'b1;
        end
      end else begin
        hi_cnt_r <= {`PRS_TMR_W{1'b0}};
        if (lo_cnt_r != OFF_LAST) begin
          lo_cnt_r <= lo_cnt_r + 1'b1;
        end
      end
      if (rise) begin
        wire_off_r <= 1'b0;
      end else if (off_hit) begin
        wire_off_r <= 1'b1;
      end
      // The first rise out of the off state only wakes the wire
      if (stop_hit | off_hit) begin
        cnt_r <= 5'h00;
      end else if (rise & ~wire_off_r & (cnt_r != 5'h1f)) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pos_code <= `PRS_POS_DEF;
      o_neg_code <= `PRS_NEG_DEF;
      pos_on_r <= 1'b1;
      neg_on_r <= 1'b1;
      neg_slow_r <= 1'b0;
      last_cmd_r <= 5'h00;
      // Settings hold until a new command, a soft reset or the reset pin
    end else if (do_cmd) begin
      last_cmd_r <= cmd;
      if (cmd_pos_set) begin
        o_pos_code <= cmd[2:0] - 3'h1;
      end else if (cmd_neg_set) begin
        o_neg_code <= cmd[2:0] - 3'h1;
      end else if (cmd_pos_on) begin
        pos_on_r <= 1'b1;
      end else if (cmd_neg_on) begin
        neg_on_r <= 1'b1;
        neg_slow_r <= 1'b0;
      end else if (cmd_pos_off) begin
        pos_on_r <= 1'b0;
      end else if (cmd_neg_off) begin
        neg_on_r <= 1'b0;
      end else if (cmd_neg_slow) begin
        neg_slow_r <= 1'b1;
      end else if (cmd_defaults) begin
        o_pos_code <= `PRS_POS_DEF;
        o_neg_code <= `PRS_NEG_DEF;
        pos_on_r <= 1'b1;
        neg_on_r <= 1'b1;
        neg_slow_r <= 1'b0;
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fda_cnt_r <= FDA_END;
      slow_cnt_r <= FDA_END;
    end else begin
      if (en) begin
        fda_cnt_r <= {`PRS_TMR_W{1'b0}};
      end else if (fda_cnt_r < FDA_END) begin
        fda_cnt_r <= fda_cnt_r + 1'b1;
      end
      // The slow window reuses the timed length, for want of a figure of its own
      if (do_cmd & cmd_neg_slow) begin
        slow_cnt_r <= {`PRS_TMR_W{1'b0}};
      end else if (slow_cnt_r < FDA_END) begin
        slow_cnt_r <= slow_cnt_r + 1'b1;
      end
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_short_fault_latch <= 1'b0;
      otp_r <= 1'b0;
      // Register words, built apart so each field's place is plain to see
    end
  end

  // Status bit 1 shows the wire asleep; the live count sits in bits 20 to 16
  wire [31:0] cmd_word = {27'h0000000, last_cmd_r};
  wire [31:0] stat_word = {11'h000, cnt_r, 7'h00, o_pos_pump_bypass,
    o_panel_neg_rail_en, o_panel_pos_rail_en, o_analog_rail_en,
    o_short_fault_latch, otp_r, i_undervolt_lockout, wire_off_r, o_shutdown};
  wire [31:0] set_word = {16'h0000, o_pos_pump_target, 1'b0, pos_on_r, neg_on_r,
    neg_slow_r, o_neg_code, o_pos_code};
  wire rd_first = i_avs_read & ~ack_r;

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_short_fault_latch <= 1'b0;
      otp_r <= 1'b0;
      oc_lat_r <= 2'h0;
    end else begin
      // A short latches; lockout or a long joint low releases it
      // A new short in the clearing cycle keeps the latch set
      if (short_set) begin
        o_short_fault_latch <= 1'b1;
      end else if (short_clr) begin
        o_short_fault_latch <= 1'b0;
      end
      // Hot sets and cooled clears; the set wins if both stand
      if (i_overtemp) begin
        otp_r <= 1'b1;
      end else if (i_cooled) begin
        otp_r <= 1'b0;
      end
      // The overcurrent latch lasts until the on-period ends
      oc_lat_r <= i_sw_on_req & (oc_lat_r | i_sw_oc);
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shutdown <= 1'b0;
      o_analog_rail_en <= 1'b0;
      o_pos_pump_en <= 1'b0;
      o_neg_pump_en <= 1'b0;
      o_pos_pump_bypass <= 1'b0;
      o_pos_pump_target <= 6'h00;
      o_panel_pos_rail_en <= 1'b0;
      o_panel_neg_rail_en <= 1'b0;
      o_analog_fast_discharge <= 1'b0;
      o_pos_fast_discharge <= 1'b0;
      o_neg_timed_fast_discharge <= 1'b0;
      o_neg_slow_discharge <= 1'b0;
      o_pos_hiz <= 1'b0;
      o_neg_hiz <= 1'b0;
    end else begin
      // Rail, pump and discharge outputs are registered so they never glitch; o_sw_gate is not
      o_shutdown <= both_low;
      o_analog_rail_en <= an_rail_nxt;
      o_pos_pump_en <= pos_pump_nxt;
      o_neg_pump_en <= neg_pump_nxt;
      o_pos_pump_target <= target_nxt;
      o_pos_pump_bypass <= i_vin_above_target;
      o_panel_pos_rail_en <= pos_rail_nxt;
      o_panel_neg_rail_en <= neg_rail_nxt;
      o_analog_fast_discharge <= an_fd_nxt;
      o_pos_fast_discharge <= pos_fd_nxt;
      o_neg_timed_fast_discharge <= neg_fda_nxt;
      o_neg_slow_discharge <= neg_slow_nxt;
      o_pos_hiz <= pos_hiz_nxt;
      o_neg_hiz <= neg_hiz_nxt;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      // Every access takes one wait cycle; read data load in the first
      ack_r <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (rd_first) begin
        if (i_avs_address == `PRS_REG_CMD) begin
          o_avs_readdata <= cmd_word;
        end else if (i_avs_address == `PRS_REG_STAT) begin
          o_avs_readdata <= stat_word;
        end else if (i_avs_address == `PRS_REG_SET) begin
          o_avs_readdata <= set_word;
        end else begin
          o_avs_readdata <= 32'h00000000;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> prs_defs.vh
// Constants of the pulse count rail sequencer: offsets, fields, resets, timings.
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH

`define PRS_CLK_MHZ 40
`define PRS_T_STOP_US 300
`define PRS_T_OFF_DLY_US 300
`define PRS_T_FDA_MS 30
`define PRS_STOP_CYC (`PRS_T_STOP_US * `PRS_CLK_MHZ)
`define PRS_OFF_CYC (`PRS_T_OFF_DLY_US * `PRS_CLK_MHZ)
`define PRS_FDA_CYC (`PRS_T_FDA_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_TMR_W 21

`define PRS_REG_CMD 4'h0
`define PRS_REG_STAT 4'h4
`define PRS_REG_SET 4'h8

`define PRS_POS_DEF 3'h5
`define PRS_NEG_DEF 3'h2
`define PRS_POS_BASE 6'h1c
`define PRS_NEG_BASE 6'h23
`define PRS_ANALOG_RAIL_MAG 6'h21
`define PRS_HEADROOM 6'h03

`define PRS_CMD_POS_LO 5'h01
`define PRS_CMD_POS_HI 5'h08
`define PRS_CMD_NEG_LO 5'h09
`define PRS_CMD_NEG_HI 5'h10
`define PRS_CMD_POS_ON 5'h13
`define PRS_CMD_NEG_ON 5'h14
`define PRS_CMD_POS_OFF 5'h15
`define PRS_CMD_NEG_OFF 5'h16
`define PRS_CMD_NEG_SLOW 5'h17
`define PRS_CMD_SOFT_RST 5'h18

`define PRS_ST_SHDN 0
`define PRS_ST_WOFF 1
`define PRS_ST_UNDERVOLT_LOCKOUT 2
`define PRS_ST_OTP 3
`define PRS_ST_SHORT 4
`define PRS_ST_ARAIL 5
`define PRS_ST_PRAIL 6
`define PRS_ST_NRAIL 7
`define PRS_ST_BYP 8
`define PRS_ST_CNT 16

`endif

// >>> prs_monitor.sv
// Port checker of the pulse count rail sequencer
`timescale 1ns/10ps
`default_nettype none
module prs_monitor #(parameter FDA_CYC = 50) (
  input wire logic i_core_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_pulse_wire_in, // Wire
  input wire logic i_analog_rail_enable, // Enable
  input wire logic i_undervolt_lockout, // Lockout
  input wire logic i_overtemp, // Hot
  input wire logic i_pos_pump_good, // Pump good
  input wire logic [1:0] i_sw_oc, // Overcurrent
  input wire logic [1:0] o_sw_gate, // Gates
  input wire logic o_shutdown, // Shutdown
  input wire logic o_pos_pump_en, // Pos pump
  input wire logic o_neg_pump_en, // Neg pump
  input wire logic [5:0] o_pos_pump_target, // Target
  input wire logic [2:0] o_pos_code, // Pos code
  input wire logic [2:0] o_neg_code, // Neg code
  input wire logic o_analog_fast_discharge, // Discharge
  input wire logic o_pos_fast_discharge, // Discharge
  input wire logic o_neg_timed_fast_discharge, // Timed
  input wire logic o_short_fault_latch // Latch
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [15:0] fda_cnt;
  wire [5:0] pv = 6'h1c + {3'h0, o_pos_code};
  wire [5:0] nv = 6'h23 - {3'h0, o_neg_code};
  wire [5:0] mx = (pv > nv) ? pv : nv;
  wire [5:0] tgt = ((mx > 6'h21) ? mx : 6'h21) + 6'h03;
  // Counts how long the timed discharge has stood
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) fda_cnt <= 16'h0;
    else fda_cnt <= o_neg_timed_fast_discharge ? fda_cnt + 16'h1 : 16'h0;
  end
  sequence s_both_low; !i_analog_rail_enable && !i_pulse_wire_in; endsequence
  sequence s_en_fell; $fell(i_analog_rail_enable); endsequence
  property p_shdn; s_both_low |=> o_shutdown; endproperty
  a_shdn: assert property (p_shdn) else $error("shutdown missed");
  property p_fd; !i_analog_rail_enable |=> o_analog_fast_discharge && o_pos_fast_discharge;
  endproperty
  a_fd: assert property (p_fd) else $error("fast discharge missed");
  property p_fda; s_en_fell |=> o_neg_timed_fast_discharge ##1 fda_cnt <= FDA_CYC + 1;
  endproperty
  a_fda: assert property (p_fda) else $error("timed discharge wrong");
  property p_oc; !(|(i_sw_oc & o_sw_gate)); endproperty
  a_oc: assert property (p_oc) else $error("gate on in overcurrent");
  property p_undervolt_lockout; i_undervolt_lockout |=> !o_pos_pump_en && !o_neg_pump_en; endproperty
  a_undervolt_lockout: assert property (p_undervolt_lockout) else $error("pump on in lockout");
  property p_otp; i_overtemp |-> ##2 (!o_pos_pump_en && !o_neg_pump_en); endproperty
  a_otp: assert property (p_otp) else $error("pump on when hot");
  property p_scp; o_short_fault_latch [*2] |-> !o_pos_pump_en && o_sw_gate == 2'h0;
  endproperty
  a_scp: assert property (p_scp) else $error("switching while latched");
  property p_seq; $rose(o_neg_pump_en) |-> $past(i_pos_pump_good); endproperty
  a_seq: assert property (p_seq) else $error("neg pump before pos");
  property p_tgt; ($stable(o_pos_code) && $stable(o_neg_code)) [*3] |-> o_pos_pump_target == tgt;
  endproperty
  a_tgt: assert property (p_tgt) else $error("pump target wrong");
endmodule
bind prs_rail_seq prs_monitor #(.FDA_CYC(FDA_CYC)) u_mon (.*);
`default_nettype wire

// >>> prs_host.sv
// Host model driving the pulse wire
`timescale 1ns/10ps
`default_nettype none
module prs_host #(parameter STOP = 20) (
  input wire logic i_clk, // Clock
  output var logic o_wire // Pulse wire
);
  initial o_wire = 1'b0;
  task automatic hold(input logic v, input int c);
    o_wire <= v;
    repeat (c) @(posedge i_clk);
  endtask
  // Wake rise, n pulses, then high past the stop time
  task automatic cmd(input int n);
    hold(1'b1, 6);
    repeat (n) begin
      hold(1'b0, 4);
      hold(1'b1, 4);
    end
    hold(1'b1, STOP + 4);
  endtask
endmodule
`default_nettype wire

// >>> prs_rail_seq_tb.sv
// Self-checking bench of the pulse count rail sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module prs_rail_seq_tb;
  logic i_core_clk, i_rst, i_pulse_wire_in, i_analog_rail_enable, i_undervolt_lockout;
  logic i_overtemp, i_cooled, i_pos_pump_good, i_neg_pump_good, i_vin_above_target;
  logic i_avs_read, i_avs_write, o_avs_waitrequest, o_shutdown, o_analog_rail_en;
  logic o_pos_pump_en, o_neg_pump_en, o_pos_pump_bypass, o_panel_pos_rail_en, o_pos_hiz;
  logic o_panel_neg_rail_en, o_analog_fast_discharge, o_pos_fast_discharge, o_neg_hiz;
  logic o_neg_timed_fast_discharge, o_neg_slow_discharge, o_short_fault_latch;
  logic [2:0] i_below_80, o_pos_code, o_neg_code, ep, ec;
  logic [1:0] i_sw_on_req, i_sw_oc, o_sw_gate;
  logic [3:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [5:0] o_pos_pump_target;
  int mismatches = 0;
  int n_checks = 0;
  int n;
  prs_host #(.STOP(20)) host (.i_clk(i_core_clk), .o_wire(i_pulse_wire_in));
  prs_rail_seq #(.STOP_CYC(20), .OFF_CYC(20), .FDA_CYC(50)) dut (.*);
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge i_core_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Avalon cycle; called just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    k = 0;
    do begin
      @(negedge i_core_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin mismatches++; test_done(); end
    q = o_avs_readdata;
    @(posedge i_core_clk);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask
  initial begin
    i_rst = 1'b1;
    {i_analog_rail_enable, i_undervolt_lockout, i_overtemp, i_cooled} = '0;
    {i_pos_pump_good, i_neg_pump_good, i_vin_above_target, i_avs_read, i_avs_write} = '0;
    {i_below_80, i_sw_on_req, i_sw_oc, i_avs_address} = '0;
    i_avs_writedata = '0;
    tick(3);
    i_rst <= 1'b0;
    tick(3);
    `CHK("shdn", 1'b1, o_shutdown)
    i_analog_rail_enable <= 1'b1;
    tick(3);
    `CHK("neg pump", 1'b0, o_neg_pump_en)
    i_pos_pump_good <= 1'b1;
    i_neg_pump_good <= 1'b1;
    tick(3);
    `CHK("neg pump", 1'b1, o_neg_pump_en)
    $display("test startup done");
    ep = 3'h5;
    ec = 3'h2;
    for (n = 1; n <= 18; n++) begin
      host.cmd(n);
      tick(2);
      if (n <= 8) ep = 3'(n - 1);
      else if (n <= 16) ec = 3'(n - 9);
      `CHK("pos code", ep, o_pos_code)
      `CHK("neg code", ec, o_neg_code)
    end
    for (n = 19; n <= 23; n++) begin
      host.cmd(n);
      tick(2);
      `CHK("pos on", n == 19 || n == 20, o_panel_pos_rail_en)
      `CHK("neg on", n <= 21, o_panel_neg_rail_en)
    end
    `CHK("slow", 1'b1, o_neg_slow_discharge)
    bus(1'b1, 4'h0, 32'h18);
    tick(2);
    `CHK("slow", 1'b0, o_neg_slow_discharge)
    bus(1'b0, 4'h8, 32'h0);
    `CHK("set reg", 6'h15, q[5:0])
    bus(1'b0, 4'hc, 32'h0);
    `CHK("unmapped", 32'h0, q)
    $display("test commands done");
    i_sw_on_req <= 2'b11;
    i_sw_oc <= 2'b01;
    i_vin_above_target <= 1'b1;
    tick(2);
    `CHK("gate", 2'b10, o_sw_gate)
    `CHK("bypass", 1'b1, o_pos_pump_bypass)
    {i_sw_on_req, i_sw_oc} <= 4'h0;
    host.hold(1'b0, 30);
    `CHK("hiz", 2'h3, {o_pos_hiz, o_neg_hiz})
    i_analog_rail_enable <= 1'b0;
    tick(3);
    `CHK("fd", 2'h3, {o_analog_fast_discharge, o_pos_fast_discharge})
    tick(60);
    `CHK("fda end", 1'b0, o_neg_timed_fast_discharge)
    i_analog_rail_enable <= 1'b1;
    tick(5);
    i_below_80 <= 3'h1;
    tick(3);
    `CHK("short", 1'b1, o_short_fault_latch)
    i_below_80 <= 3'h0;
    i_analog_rail_enable <= 1'b0;
    tick(30);
    `CHK("short clr", 1'b0, o_short_fault_latch)
    i_analog_rail_enable <= 1'b1;
    i_undervolt_lockout <= 1'b1;
    tick(3);
    `CHK("undervolt_lockout", 1'b0, o_pos_pump_en)
    i_undervolt_lockout <= 1'b0;
    i_overtemp <= 1'b1;
    tick(3);
    i_overtemp <= 1'b0;
    tick(3);
    `CHK("hot", 1'b0, o_pos_pump_en)
    i_cooled <= 1'b1;
    tick(3);
    `CHK("cooled", 1'b1, o_pos_pump_en)
    $display("test faults done");
    test_done();
  end
  initial begin
    tick(100000);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
